/* core/ewd_pkg.sv */
// ==========================================================
// Functional notes
// - limit bits 1:0 give type: 00 plain memory, 01 prefetchable, 1x i/o
// - memory windows decode on 4 KB steps, i/o windows on 4-byte steps
// - memory windows force bits 11:2 to ones in limit, zeros in base
// - two 32-bit limit registers, all bits writable, reset to zero
// - gate register bit 0 enables window 0, bit 1 enables window 1
// - both enable bits clear after reset, so no window decodes
// - inclusion bit per window: 0 includes, 1 excludes from primary decode
// - inclusion bits reset to zero, enabled windows included by default
// - gate and inclusion register bits 7:2 are reserved and read zero
// - with negative decode on, secondary decode is the complement of the primary decode
// - with negative decode off, secondary claims primary-excluded windows
// - only the policy register controls secondary negative decode; gate and inclusion bits control window use
// - policy settings act even while a window is disabled; inclusion bits act only while it is enabled
// - two 32-bit base registers, bits 1:0 read-only zero, rest writable
// - policy bit 1 enables secondary negative decode, resets to one
// - policy bit 0 enables secondary subtractive decode, resets to zero
// - policy bit 2 selects slow claim four clocks in while bit 0 is set, resets to one
package ewd_pkg;
  localparam int ADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_BASE0 = 10'h044;
  localparam logic [9:0] IDX_LIMIT0 = 10'h048;
  localparam logic [9:0] IDX_BASE1 = 10'h04C;
  localparam logic [9:0] IDX_LIMIT1 = 10'h050;
  localparam logic [9:0] IDX_GATE = 10'h054;
  localparam logic [9:0] IDX_INCL = 10'h055;
  localparam logic [9:0] IDX_POLICY = 10'h056;
  localparam logic [31:0] RST_BASE = 32'h0000_0000;
  localparam logic [31:0] RST_LIMIT = 32'h0000_0000;
  localparam logic [7:0] RST_GATE = 8'h00;
  localparam logic [7:0] RST_INCL = 8'h00;
  localparam logic [7:0] RST_POLICY = 8'h06;
  localparam logic [7:0] MASK_GATE = 8'h03;
  localparam logic [7:0] MASK_INCL = 8'h03;
  localparam logic [7:0] MASK_POLICY = 8'h07;
  localparam logic [31:0] MASK_BASE = 32'hFFFF_FFFC;
  localparam int POL_SUBTR = 0;
  localparam int POL_NEG = 1;
  localparam int POL_SLOW = 2;
  localparam int TYPE_IO_BIT = 1;
  localparam logic [31:0] MEM_GRAN_MASK = 32'h0000_0FFF;
  localparam logic [31:0] IO_GRAN_MASK = 32'h0000_0003;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* core/ewd_window_decoder.sv */
`timescale 1ns/100ps
module ewd_window_decoder (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // axi4-lite slave
  input wire logic [ewd_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ewd_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // decode queries from the bus agents
  input wire logic [31:0] prim_addr_in,
  input wire logic prim_is_io_in,
  input wire logic [31:0] sec_addr_in,
  input wire logic sec_is_io_in,
  // decode results
  output logic prim_forward_out,
  output logic sec_forward_out,
  output logic sec_subtractive_out,
  output logic sec_slow_claim_out
);

  // everything the block remembers, registered as one word
  typedef struct packed {
    // write channel bookkeeping
    logic aw_got;
    logic [9:0] aw_idx;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;

    // read channel state
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;

    // software-visible registers
    logic [1:0][31:0] base;
    logic [1:0][31:0] limit;
    logic [7:0] gate;
    logic [7:0] incl;
    logic [7:0] policy;

    // decode results, one edge behind the query
    logic prim_fwd;
    logic sec_fwd;
  } ewd_state_s;

  // st is the register bank, next_st its value for the coming edge
  ewd_state_s st;
  ewd_state_s next_st;

  // per-window hits for each side, and the gate that opens each window
  logic [1:0] prim_hit;
  logic [1:0] sec_hit;
  logic [1:0] win_on;

  // =========================================================
  // window match
  // bounds widen to the granule: memory windows ignore stored bits 11:2,
  // i/o windows only cover the two type bits of the limit
  function automatic logic win_match(
    input logic [31:0] base,
    input logic [31:0] limit,
    input logic [31:0] addr,
    input logic is_io
  );
    logic [31:0] lo;
    logic [31:0] hi;
    logic win_io;
    win_io = limit[ewd_pkg::TYPE_IO_BIT];
    if (win_io) begin
      lo = base & ~ewd_pkg::IO_GRAN_MASK;
      hi = limit | ewd_pkg::IO_GRAN_MASK;
    end else begin
      lo = base & ~ewd_pkg::MEM_GRAN_MASK;
      hi = limit | ewd_pkg::MEM_GRAN_MASK;
    end

    // the command type must match as well as the address range
    win_match = (addr >= lo) && (addr <= hi) && (is_io == win_io);
  endfunction

  // a window answers neither side while its gate bit is clear,
  // whatever the policy and inclusion bits say
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_win
      assign win_on[gi] = st.gate[gi];
      assign prim_hit[gi] = win_on[gi] && win_match(
        st.base[gi], st.limit[gi], prim_addr_in, prim_is_io_in
      );
      assign sec_hit[gi] = win_on[gi] && win_match(
        st.base[gi], st.limit[gi], sec_addr_in, sec_is_io_in
      );
    end
  endgenerate

  // =========================================================
  // register read mux
  // bit 32 marks a mapped index; an unmapped read answers zero with an error
  function automatic logic [32:0] reg_read(
    input ewd_state_s s,
    input logic [9:0] idx
  );
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    case (idx)
      ewd_pkg::IDX_BASE0: r = {1'b1, s.base[0]};
      ewd_pkg::IDX_BASE1: r = {1'b1, s.base[1]};
      ewd_pkg::IDX_LIMIT0: r = {1'b1, s.limit[0]};
      ewd_pkg::IDX_LIMIT1: r = {1'b1, s.limit[1]};
      // 8-bit registers sit in lane 0, the upper lanes read zero
      ewd_pkg::IDX_GATE: r = {1'b1, 24'h00_0000, s.gate};
      ewd_pkg::IDX_INCL: r = {1'b1, 24'h00_0000, s.incl};
      ewd_pkg::IDX_POLICY: r = {1'b1, 24'h00_0000, s.policy};
      default: r = {1'b0, 32'h0000_0000};
    endcase
    reg_read = r;
  endfunction

  // =========================================================
  // byte-lane merge
  // lanes the master leaves disabled keep their old contents
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0] be
  );
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    merge = m;
  endfunction

  // =========================================================
  // next state
  // one pass computes the whole next state, bus and decode alike
  always_comb begin
    logic [32:0] rd;
    logic mapped;
    rd = {1'b0, 32'h0000_0000};
    mapped = 1'b1;
    next_st = st;

    // write channels, taken in either order; an early half is held
    // until its partner comes, so the master may offer them apart
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_st.aw_got = 1'b1;
      next_st.aw_idx = s_axi_awaddr_in[ewd_pkg::ADDR_W-1:2];
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata_in;
      next_st.wstrb = s_axi_wstrb_in;
    end
    // applied one edge after both halves are held, so the register
    // contents and bvalid change at the same edge
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      case (st.aw_idx)
        ewd_pkg::IDX_BASE0: begin
          next_st.base[0] = merge(st.base[0], st.wdata, st.wstrb) & ewd_pkg::MASK_BASE;
        end
        ewd_pkg::IDX_BASE1: begin
          next_st.base[1] = merge(st.base[1], st.wdata, st.wstrb) & ewd_pkg::MASK_BASE;
        end
        ewd_pkg::IDX_LIMIT0: begin
          next_st.limit[0] = merge(st.limit[0], st.wdata, st.wstrb);
        end
        ewd_pkg::IDX_LIMIT1: begin
          next_st.limit[1] = merge(st.limit[1], st.wdata, st.wstrb);
        end
        ewd_pkg::IDX_GATE: begin
          if (st.wstrb[0]) begin
            next_st.gate = st.wdata[7:0] & ewd_pkg::MASK_GATE;
          end
        end
        ewd_pkg::IDX_INCL: begin
          if (st.wstrb[0]) begin
            next_st.incl = st.wdata[7:0] & ewd_pkg::MASK_INCL;
          end
        end
        ewd_pkg::IDX_POLICY: begin
          // reserved bits 7:3 are dropped, so they read back zero
          if (st.wstrb[0]) begin
            next_st.policy = st.wdata[7:0] & ewd_pkg::MASK_POLICY;
          end
        end
        // an unmapped index changes nothing and answers with an error
        default: mapped = 1'b0;
      endcase
      if (mapped) begin
        next_st.bresp = ewd_pkg::RESP_OKAY;
      end else begin
        next_st.bresp = ewd_pkg::RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end

    // read channel; arready only rises again once the answer has gone,
    // so a release and a new address never meet in one cycle
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      rd = reg_read(st, s_axi_araddr_in[ewd_pkg::ADDR_W-1:2]);
      next_st.rvalid = 1'b1;
      next_st.rdata = rd[31:0];
      if (rd[32]) begin
        next_st.rresp = ewd_pkg::RESP_OKAY;
      end else begin
        next_st.rresp = ewd_pkg::RESP_SLVERR;
      end
    end

    // results are registered: a query is answered one edge later,
    // and a register write steers decode from the edge after it lands
    // primary claims enabled windows that are included
    next_st.prim_fwd = |(prim_hit & ~st.incl[1:0]);
    if (st.policy[ewd_pkg::POL_NEG]) begin
      // upstream takes whatever primary would not forward downstream
      next_st.sec_fwd = ~|(sec_hit & ~st.incl[1:0]);
    end else begin
      // positive decode of windows kept off the primary side
      next_st.sec_fwd = |(sec_hit & st.incl[1:0]);
    end
  end

  // =========================================================
  // state register
  // the reset branch loads constants only
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st.aw_got <= 1'b0;
      st.aw_idx <= 10'h000;
      st.w_got <= 1'b0;
      st.wdata <= 32'h0000_0000;
      st.wstrb <= 4'h0;
      st.bvalid <= 1'b0;
      st.bresp <= ewd_pkg::RESP_OKAY;
      st.rvalid <= 1'b0;
      st.rdata <= 32'h0000_0000;
      st.rresp <= ewd_pkg::RESP_OKAY;
      st.base[0] <= ewd_pkg::RST_BASE;
      st.base[1] <= ewd_pkg::RST_BASE;
      st.limit[0] <= ewd_pkg::RST_LIMIT;
      st.limit[1] <= ewd_pkg::RST_LIMIT;
      st.gate <= ewd_pkg::RST_GATE;
      st.incl <= ewd_pkg::RST_INCL;
      st.policy <= ewd_pkg::RST_POLICY;
      st.prim_fwd <= 1'b0;
      st.sec_fwd <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // =========================================================
  // write channel outputs
  // a new address is refused until the pending write is answered
  assign s_axi_awready_out = !st.aw_got && !st.bvalid;
  assign s_axi_wready_out = !st.w_got && !st.bvalid;
  assign s_axi_bvalid_out = st.bvalid;
  assign s_axi_bresp_out = st.bresp;

  // =========================================================
  // read channel outputs
  // one read at a time: no new address while an answer waits
  assign s_axi_arready_out = !st.rvalid;
  assign s_axi_rvalid_out = st.rvalid;
  assign s_axi_rdata_out = st.rdata;
  assign s_axi_rresp_out = st.rresp;

  // =========================================================
  // decode outputs
  assign prim_forward_out = st.prim_fwd;
  assign sec_forward_out = st.sec_fwd;
  assign sec_subtractive_out = st.policy[ewd_pkg::POL_SUBTR];
  // slow slot only means something with subtractive decode on
  assign sec_slow_claim_out = st.policy[ewd_pkg::POL_SUBTR] && st.policy[ewd_pkg::POL_SLOW];

endmodule // ewd_window_decoder

/* tb/ewd_window_monitor.sv */
`timescale 1ns/100ps
// ==========================================================
// handshake and decode output checks
module ewd_window_monitor (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic prim_forward_out,
  input wire logic sec_subtractive_out,
  input wire logic sec_slow_claim_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##[1:2] s_axi_bvalid_out) else $error("write answer late");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write answer dropped");
  a_write_refused: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while answer pending");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read answer dropped");
  a_read_refused: assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("read taken while busy");
  a_slow_gated: assert property (sec_slow_claim_out |-> sec_subtractive_out) else $error("slow claim ungated");
  a_reset_quiet: assert property ($fell(sys_rst_in) |-> (!prim_forward_out && !sec_subtractive_out)[*2])
    else $error("decode active after reset");
  c_prim_hit: cover property (prim_forward_out);
  c_slow_claim: cover property (sec_slow_claim_out);
  c_unmapped: cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'b10);
endmodule // ewd_window_monitor

bind ewd_window_decoder ewd_window_monitor i_ewd_window_monitor (.sys_clk_in, .sys_rst_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in, .prim_forward_out,
  .sec_subtractive_out, .sec_slow_claim_out);

/* tb/ewd_bus_agent.sv */
`timescale 1ns/100ps
// ==========================================================
// agents on both buses issuing one query
module ewd_bus_agent (
  input wire logic [31:0] query_addr_in,
  input wire logic query_io_in,
  output logic [31:0] prim_addr_out,
  output logic [31:0] sec_addr_out,
  output logic prim_io_out,
  output logic sec_io_out
);
  // same query on both sides makes the complement directly visible
  assign prim_addr_out = query_addr_in;
  assign sec_addr_out = query_addr_in;
  assign prim_io_out = query_io_in;
  assign sec_io_out = query_io_in;
endmodule // ewd_bus_agent

/* tb/ewd_window_decoder_test.sv */
`timescale 1ns/100ps
module ewd_window_decoder_test;
  logic sys_clk_in, sys_rst_in, query_io;
  logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, prim_addr_in, sec_addr_in, query_addr, bas[2], lim[2];
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in, prim_is_io_in, sec_is_io_in;
  logic prim_forward_out, sec_forward_out, sec_subtractive_out, sec_slow_claim_out;
  logic [7:0] gate, incl, pol;
  logic [9:0] idx_tab[7] = '{ewd_pkg::IDX_BASE0, ewd_pkg::IDX_LIMIT0, ewd_pkg::IDX_BASE1, ewd_pkg::IDX_LIMIT1,
    ewd_pkg::IDX_GATE, ewd_pkg::IDX_INCL, ewd_pkg::IDX_POLICY};
  int failures, samples_checked;
  ewd_window_decoder i_ewd_window_decoder (.sys_clk_in, .sys_rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .prim_addr_in, .prim_is_io_in, .sec_addr_in, .sec_is_io_in,
    .prim_forward_out, .sec_forward_out, .sec_subtractive_out, .sec_slow_claim_out);
  ewd_bus_agent i_ewd_bus_agent (.query_addr_in(query_addr), .query_io_in(query_io), .prim_addr_out(prim_addr_in),
    .sec_addr_out(sec_addr_in), .prim_io_out(prim_is_io_in), .sec_io_out(sec_is_io_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  task automatic axi_wr(input logic [9:0] idx, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= {idx, 2'b00};
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(negedge sys_clk_in);
      ta = s_axi_awvalid_in & s_axi_awready_out;
      tw = s_axi_wvalid_in & s_axi_wready_out;
      tb = s_axi_bvalid_out;
      r = s_axi_bresp_out;
      @(posedge sys_clk_in);
      if (ta) s_axi_awvalid_in <= 1'b0;
      if (tw) s_axi_wvalid_in <= 1'b0;
    end while (tb !== 1'b1);
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic axi_rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge sys_clk_in);
    s_axi_araddr_in <= {idx, 2'b00};
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(negedge sys_clk_in);
      ta = s_axi_arready_out;
      tr = s_axi_rvalid_out;
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
      @(posedge sys_clk_in);
      if (ta) s_axi_arvalid_in <= 1'b0;
    end while (tr !== 1'b1);
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(idx, d, r);
    chk_val(d, e);
    chk_val({30'h0, r}, 32'h0000_0000);
  endtask
  task automatic cfg(input logic [31:0] v[7]);
    logic [1:0] r;
    foreach (idx_tab[i]) begin
      axi_wr(idx_tab[i], v[i], r);
      chk_val({30'h0, r}, 32'h0000_0000);
    end
    bas = '{v[0] & 32'hffff_fffc, v[2] & 32'hffff_fffc};
    lim = '{v[1], v[3]};
    gate = v[4][7:0] & 8'h03;
    incl = v[5][7:0] & 8'h03;
    pol = v[6][7:0] & 8'h07;
  endtask
  function automatic logic hit(int w, logic [31:0] a, logic io);
    logic [31:0] m;
    m = lim[w][1] ? 32'h0000_0003 : 32'h0000_0fff;
    return gate[w] && (lim[w][1] == io) && a >= (bas[w] & ~m) && a <= (lim[w] | m);
  endfunction
  task automatic dec_chk(input logic [31:0] a, input logic io);
    logic ph, sx;
    @(posedge sys_clk_in);
    query_addr <= a;
    query_io <= io;
    repeat (2) @(negedge sys_clk_in);
    ph = (hit(0, a, io) && !incl[0]) || (hit(1, a, io) && !incl[1]);
    sx = (hit(0, a, io) && incl[0]) || (hit(1, a, io) && incl[1]);
    chk_flag(prim_forward_out, ph);
    chk_flag(sec_forward_out, pol[1] ? !ph : sx);
    chk_flag(sec_subtractive_out, pol[0]);
    chk_flag(sec_slow_claim_out, pol[0] & pol[2]);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    failures++;
    conclude();
  end
  initial begin
    logic [31:0] v[7], d, m;
    logic [1:0] r;
    d = $urandom(32'h14de7d6a);
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, query_addr, query_io} = '0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
    s_axi_wstrb_in = 4'hf;
    bas = '{32'h0, 32'h0};
    lim = '{32'h0, 32'h0};
    {gate, incl, pol} = {8'h00, 8'h00, 8'h06};
    sys_rst_in = 1'b1;
    repeat (8) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    dec_chk(32'h0000_0000, 1'b0);
    foreach (idx_tab[i]) rd_chk(idx_tab[i], i == 6 ? 32'h0000_0006 : 32'h0);
    axi_wr(10'h003, 32'hffff_ffff, r);
    chk_val({30'h0, r}, 32'h0000_0002);
    axi_rd(10'h003, d, r);
    chk_val({30'h0, r}, 32'h0000_0002);
    chk_val(d, 32'h0000_0000);
    foreach (v[i]) v[i] = 32'hffff_ffff;
    cfg(v);
    foreach (idx_tab[i]) rd_chk(idx_tab[i], i > 3 ? {24'h0, i == 6 ? 8'h07 : 8'h03}
      : (i[0] ? 32'hffff_ffff : 32'hffff_fffc));
    // partial strobes: 32-bit registers merge by lane, 8-bit ones need lane 0
    s_axi_wstrb_in <= 4'h5;
    axi_wr(ewd_pkg::IDX_LIMIT0, 32'h0000_0000, r);
    rd_chk(ewd_pkg::IDX_LIMIT0, 32'hff00_ff00);
    s_axi_wstrb_in <= 4'he;
    axi_wr(ewd_pkg::IDX_GATE, 32'h0000_0000, r);
    rd_chk(ewd_pkg::IDX_GATE, 32'h0000_0003);
    s_axi_wstrb_in <= 4'hf;
    repeat (40) begin
      foreach (v[i]) v[i] = $urandom;
      v[0] &= 32'h000f_fffc;
      v[2] &= 32'h000f_fffc;
      v[1] = v[0] + (v[1] & 32'h0000_3fff);
      v[3] = v[2] + (v[3] & 32'h0000_3fff);
      cfg(v);
      for (int w = 0; w < 2; w++) begin
        m = lim[w][1] ? 32'h0000_0003 : 32'h0000_0fff;
        // edges either side of each adjusted bound, then the wrong command type
        dec_chk((bas[w] & ~m) - 32'h1, lim[w][1]);
        dec_chk(bas[w] & ~m, lim[w][1]);
        dec_chk(lim[w] | m, lim[w][1]);
        dec_chk((lim[w] | m) + 32'h1, lim[w][1]);
        dec_chk(bas[w] | m, !lim[w][1]);
      end
    end
    // mid-run reset must bring back every default
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    bas = '{32'h0, 32'h0};
    lim = '{32'h0, 32'h0};
    {gate, incl, pol} = {8'h00, 8'h00, 8'h06};
    dec_chk(32'h0000_0000, 1'b0);
    foreach (idx_tab[i]) rd_chk(idx_tab[i], i == 6 ? 32'h0000_0006 : 32'h0);
    conclude();
  end
endmodule // ewd_window_decoder_test
